// *** adccs_ctrl.sv ***
// Converter control register, conversion sequencer and AXI4-Lite slave.
//
// Implementation choices: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
`include "adccs_defs.svh"

module adccs_ctrl (
  // Clock, reset and enable.
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  // AXI4-Lite write address channel.
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data channel.
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response channel.
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address channel.
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data channel.
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Analog converter side.
  input wire logic conv_done,
  output logic converter_power_on,
  output logic conv_start,
  output adccs_pkg::adccs_route_t route,
  // Interrupt.
  output logic irq
);

  // ----------------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------------
  // Returns a one-hot hit vector {iclr, ien, sts, ctrl}; zero if unmapped.
  function automatic logic [3:0] reg_hit(input logic [7:0] a);
    logic [3:0] h;
    h = 4'h0;
    h[0] = (a == `ADCCS_OFF_CTRL);
    h[1] = (a == `ADCCS_OFF_STS);
    h[2] = (a == `ADCCS_OFF_IEN);
    h[3] = (a == `ADCCS_OFF_ICLR);
    return h;
  endfunction

  // ----------------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------------
  // Bus channel state.
  logic awready_r;
  logic wready_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic arready_r;
  logic rvalid_r;
  logic [1:0] rresp_r;
  logic [31:0] rdata_r;
  // Captured write address, data and strobes.
  logic [7:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  // Control register fields.
  logic [4:0] sel_r;
  logic pwr_r;
  // Conversion sequencer.
  adccs_pkg::adccs_conv_t state_r;
  adccs_pkg::adccs_conv_t state_nxt;
  logic start_r;
  // Done input synchroniser and its filtered level.
  logic [2:0] done_s_r;
  logic done_lvl_r;
  // Interrupt status, enable and output.
  logic sts_r;
  logic ien_r;
  logic irq_r;

  // ----------------------------------------------------------------------
  // Bus handshakes
  // ----------------------------------------------------------------------
  // A channel moves only on an enabled edge with valid and ready high.
  logic aw_take;
  logic w_take;
  logic b_done;
  logic ar_take;
  logic r_done;
  logic wr_do;
  logic [3:0] whit;
  logic [3:0] rhit;
  logic lane0;

  assign aw_take = ce && s_axi_awvalid && awready_r;
  assign w_take = ce && s_axi_wvalid && wready_r;
  assign b_done = ce && bvalid_r && s_axi_bready;
  assign ar_take = ce && s_axi_arvalid && arready_r;
  assign r_done = ce && rvalid_r && s_axi_rready;
  // Both halves captured and no response pending: commit the write.
  assign wr_do = ce && !awready_r && !wready_r && !bvalid_r;
  assign whit = reg_hit(awaddr_r);
  assign rhit = reg_hit(s_axi_araddr);
  // Every field lives in the low byte, so only lane 0 writes matter.
  assign lane0 = wstrb_r[0];

  // ----------------------------------------------------------------------
  // Register write decode
  // ----------------------------------------------------------------------
  logic ctrl_wr;
  logic ien_wr;
  logic clr_wr;
  logic pwr_nxt;
  logic go_req;

  assign ctrl_wr = wr_do && whit[0] && lane0;
  assign ien_wr = wr_do && whit[2] && lane0;
  assign clr_wr = wr_do && whit[3] && lane0;
  // The power bit of the same write counts, so one write may power and go.
  assign pwr_nxt = ctrl_wr ? wdata_r[`ADCCS_BIT_PWR] : pwr_r;
  // A start while busy or unpowered is ignored; a zero start bit never aborts, but a zero power bit does.
  assign go_req = ctrl_wr && wdata_r[`ADCCS_BIT_GO] && pwr_nxt;

  // ----------------------------------------------------------------------
  // Done input filter
  // ----------------------------------------------------------------------
  // The converter may run from another clock, so its done level is
  // resynchronised and only accepted once two late stages agree.
  logic done_rise;

  assign done_rise = (done_s_r[1] == done_s_r[2]) && done_s_r[2] &&
                     !done_lvl_r;

  // Three-stage shift; stage 0 feeds only stage 1.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      done_s_r <= 3'h0;
    else if (ce)
      done_s_r <= {done_s_r[1:0], conv_done};
  end

  // Filtered level follows the input once the late stages agree.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      done_lvl_r <= 1'b0;
    else if (ce && done_s_r[1] == done_s_r[2])
      done_lvl_r <= done_s_r[2];
  end

  // ----------------------------------------------------------------------
  // Conversion sequencer
  // ----------------------------------------------------------------------
  logic busy;
  logic fin;

  assign busy = (state_r == adccs_pkg::ADCCS_BUSY);
  // Completion is a done edge while busy; a stale edge in idle is dropped.
  assign fin = busy && done_rise;

  // Next state: powering off aborts a conversion without a done event.
  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      adccs_pkg::ADCCS_IDLE:
      begin
        if (go_req)
          state_nxt = adccs_pkg::ADCCS_BUSY;
      end
      adccs_pkg::ADCCS_BUSY:
      begin
        if (!pwr_nxt || done_rise)
          state_nxt = adccs_pkg::ADCCS_IDLE;
      end
    endcase
  end

  // State register and the one-cycle start pulse to the converter.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_r <= adccs_pkg::ADCCS_IDLE;
      start_r <= 1'b0;
    end
    else if (ce)
    begin
      state_r <= state_nxt;
      start_r <= !busy && go_req;
    end
  end

  // ----------------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------------
  // The start bit has no storage of its own: it reads the sequencer.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sel_r <= `ADCCS_RST_SEL;
      pwr_r <= 1'b0;
    end
    else if (ce && ctrl_wr)
    begin
      sel_r <= wdata_r[`ADCCS_SEL_HI:`ADCCS_SEL_LO];
      pwr_r <= wdata_r[`ADCCS_BIT_PWR];
    end
  end

  // Route selects are decoded and registered in the leaf.
  adccs_route_dec u_route (
    .clk(clk),
    .rst_b(rst_b),
    .ce(ce),
    .sel(sel_r),
    .route_r(route)
  );

  // ----------------------------------------------------------------------
  // Interrupt
  // ----------------------------------------------------------------------
  // A completion in the same cycle as a clear keeps the bit set.
  logic clr_bit;

  assign clr_bit = clr_wr && wdata_r[`ADCCS_IRQ_DONE];

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sts_r <= 1'b0;
      ien_r <= 1'b0;
      irq_r <= 1'b0;
    end
    else if (ce)
    begin
      sts_r <= fin || (sts_r && !clr_bit);
      if (ien_wr)
        ien_r <= wdata_r[`ADCCS_IRQ_DONE];
      // One cycle behind status, traded for a flop-driven output.
      irq_r <= sts_r && ien_r;
    end
  end

  // ----------------------------------------------------------------------
  // Write channels
  // ----------------------------------------------------------------------
  // Address and data are captured independently; ready drops once taken
  // and returns only when the response has been accepted.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      awready_r <= 1'b1;
      wready_r <= 1'b1;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
    end
    else if (ce)
    begin
      if (aw_take)
      begin
        awready_r <= 1'b0;
        awaddr_r <= s_axi_awaddr;
      end
      else if (b_done)
        awready_r <= 1'b1;
      if (w_take)
      begin
        wready_r <= 1'b0;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      else if (b_done)
        wready_r <= 1'b1;
    end
  end

  // Write response; an unmapped address answers with a slave error.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      bvalid_r <= 1'b0;
      bresp_r <= `ADCCS_RESP_OKAY;
    end
    else if (ce)
    begin
      if (wr_do)
      begin
        bvalid_r <= 1'b1;
        bresp_r <= (whit == 4'h0) ? `ADCCS_RESP_SLVERR : `ADCCS_RESP_OKAY;
      end
      else if (b_done)
        bvalid_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Read channels
  // ----------------------------------------------------------------------
  // Unused and write-only locations read as zero.
  logic [31:0] ctrl_word;
  logic [31:0] rd_word;

  assign ctrl_word = {24'h00_0000, 1'b0, sel_r, busy, pwr_r};
  assign rd_word = rhit[0] ? ctrl_word :
                   rhit[1] ? {31'h0000_0000, sts_r} :
                   rhit[2] ? {31'h0000_0000, ien_r} : 32'h0000_0000;

  // Read data is captured at the address edge and answered one cycle on.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= `ADCCS_RESP_OKAY;
    end
    else if (ce)
    begin
      if (ar_take)
      begin
        arready_r <= 1'b0;
        rvalid_r <= 1'b1;
        rdata_r <= rd_word;
        rresp_r <= (rhit == 4'h0) ? `ADCCS_RESP_SLVERR : `ADCCS_RESP_OKAY;
      end
      else if (r_done)
      begin
        arready_r <= 1'b1;
        rvalid_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  // The power bit gates the converter bias directly.
  assign converter_power_on = pwr_r;
  assign conv_start = start_r;
  assign irq = irq_r;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  property p_go_start;
    @(posedge clk) disable iff (!rst_b)
    (go_req && !busy) |=> busy && conv_start ##1 !conv_start;
  endproperty
  a_go_start: assert property (p_go_start)
    else $error("start write did not launch a conversion");

  property p_go_clear;
    @(posedge clk) disable iff (!rst_b)
    (busy && ce && done_rise) |=> !busy && sts_r;
  endproperty
  a_go_clear: assert property (p_go_clear)
    else $error("start bit not cleared at conversion end");

  property p_go_read;
    @(posedge clk) disable iff (!rst_b)
    (ar_take && rhit[0]) |=> s_axi_rvalid &&
      s_axi_rdata[`ADCCS_BIT_GO] == $past(busy);
  endproperty
  a_go_read: assert property (p_go_read)
    else $error("start bit read does not show conversion state");

  property p_pwr;
    @(posedge clk) disable iff (!rst_b)
    ctrl_wr |=> converter_power_on == $past(wdata_r[`ADCCS_BIT_PWR]) &&
      (converter_power_on || !busy);
  endproperty
  a_pwr: assert property (p_pwr)
    else $error("power bit and converter state disagree");

  property p_unimp;
    @(posedge clk) disable iff (!rst_b)
    s_axi_rvalid |-> s_axi_rdata[`ADCCS_BIT_UNIMP] == 1'b0;
  endproperty
  a_unimp: assert property (p_unimp)
    else $error("unimplemented bit read as one");

endmodule

// *** adccs_ctrl_tb_top.sv ***
// Self-checking testbench for the adccs converter control block.
`timescale 1ns/1ps
`include "adccs_defs.svh"

module adccs_ctrl_tb_top;
  // Clock, reset and enable.
  logic clk;
  logic rst_b;
  logic ce;
  // Register bus.
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  // Converter side and interrupt.
  logic conv_done, converter_power_on, conv_start, irq;
  adccs_pkg::adccs_route_t route;
  // Counters of the run.
  int err_count = 0;
  int comparisons = 0;
  int starts = 0;
  logic [31:0] rd;
  logic [1:0] rsp;

  adccs_ctrl uut (.clk(clk), .rst_b(rst_b), .ce(ce),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .conv_done(conv_done),
    .converter_power_on(converter_power_on), .conv_start(conv_start),
    .route(route), .irq(irq));

  // A 40 MHz clock.
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Launch pulses are counted so that a missing or doubled one shows.
  always @(posedge clk)
  begin
    if (conv_start === 1'b1)
      starts++;
  end

  // Compares one value and reports a mismatch at once.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One write; address and data are offered together and held until taken.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (n < 100)
    begin
      @(posedge clk);
      n++;
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && s_axi_bready)
      begin
        rsp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        n = 1000;
      end
    end
    if (n != 1000)
      chk(32'h0, 32'h1);
  endtask

  // One read; the data is taken at the edge that sees rvalid high.
  task automatic rdw(input logic [7:0] a);
    int n;
    n = 0;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (n < 100)
    begin
      @(posedge clk);
      n++;
      if (s_axi_arvalid && s_axi_arready)
        s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && s_axi_rready)
      begin
        rd = s_axi_rdata;
        rsp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        n = 1000;
      end
    end
    if (n != 1000)
      chk(32'h0, 32'h1);
  endtask

  // The converter reports a finished conversion, held well past the filter.
  task automatic done_pulse();
    @(posedge clk);
    conv_done <= 1'b1;
    repeat (6) @(posedge clk);
    conv_done <= 1'b0;
    repeat (6) @(posedge clk);
  endtask

  // Select expected for a route code, worked out from the code map.
  function automatic adccs_pkg::adccs_route_t exp_route(input logic [4:0] c);
    adccs_pkg::adccs_route_t r;
    r = '0;
    if (c <= `ADCCS_CODE_AIN_MAX)
      r.ain[c] = 1'b1;
    else if (c == `ADCCS_CODE_TEMP)
      r.temp = 1'b1;
    else if (c == `ADCCS_CODE_LADDER)
      r.ladder = 1'b1;
    else if (c == `ADCCS_CODE_FIXREF)
      r.fixref = 1'b1;
    return r;
  endfunction

  // Values straight after reset.
  task automatic test_reset();
    rdw(`ADCCS_OFF_CTRL);
    chk(rd, 32'h0);
    chk(rsp, `ADCCS_RESP_OKAY);
    chk(converter_power_on, 1'b0);
    rdw(`ADCCS_OFF_STS);
    chk(rd, 32'h0);
    chk(irq, 1'b0);
    $display("Test reset finished");
  endtask

  // Every route code, with bit 7 written high to prove it reads zero.
  task automatic test_routes();
    for (int i = 0; i < 32; i++)
    begin
      wr(`ADCCS_OFF_CTRL, {24'h0, 1'b1, i[4:0], 2'h0});
      repeat (3) @(posedge clk);
      if (i <= 11)
        chk(route, exp_route(i[4:0]));
      else if (i <= 28)
        chk(route, exp_route(i[4:0]));
      else if (i == 29)
        chk(route, exp_route(i[4:0]));
      else
        chk(route, exp_route(i[4:0]));
      rdw(`ADCCS_OFF_CTRL);
      chk(rd, {24'h0, 1'b0, i[4:0], 2'h0});
    end
    $display("Test routes finished");
  endtask

  // A full conversion with the interrupt enabled, then cleared.
  task automatic test_conv();
    int s0;
    wr(`ADCCS_OFF_IEN, 32'h1);
    // Power and route first, then start in a separate write.
    wr(`ADCCS_OFF_CTRL, 32'h15);
    s0 = starts;
    wr(`ADCCS_OFF_CTRL, 32'h17);
    repeat (2) @(posedge clk);
    chk(starts - s0, 1);
    chk(converter_power_on, 1'b1);
    rdw(`ADCCS_OFF_CTRL);
    chk(rd, 32'h17);
    chk(route, exp_route(5'h05));
    done_pulse();
    rdw(`ADCCS_OFF_CTRL);
    chk(rd, 32'h15);
    rdw(`ADCCS_OFF_STS);
    chk(rd, 32'h1);
    chk(irq, 1'b1);
    // The status register ignores writes; only the clear register works.
    wr(`ADCCS_OFF_STS, 32'h0);
    chk(rsp, `ADCCS_RESP_OKAY);
    rdw(`ADCCS_OFF_STS);
    chk(rd, 32'h1);
    wr(`ADCCS_OFF_ICLR, 32'h1);
    repeat (2) @(posedge clk);
    chk(irq, 1'b0);
    rdw(`ADCCS_OFF_ICLR);
    chk(rd, 32'h0);
    $display("Test conversion finished");
  endtask

  // A refused unpowered start, an abort, a masked event and an unmapped address.
  task automatic test_refuse();
    int s0;
    s0 = starts;
    wr(`ADCCS_OFF_CTRL, 32'h02);
    repeat (2) @(posedge clk);
    chk(starts - s0, 0);
    rdw(`ADCCS_OFF_CTRL);
    chk(rd, 32'h0);
    wr(`ADCCS_OFF_CTRL, 32'h03);
    wr(`ADCCS_OFF_CTRL, 32'h00);
    repeat (2) @(posedge clk);
    chk(converter_power_on, 1'b0);
    rdw(`ADCCS_OFF_CTRL);
    chk(rd, 32'h0);
    // Masked: the status bit sets but the interrupt stays low.
    wr(`ADCCS_OFF_IEN, 32'h0);
    wr(`ADCCS_OFF_CTRL, 32'h03);
    done_pulse();
    rdw(`ADCCS_OFF_STS);
    chk(rd, 32'h1);
    chk(irq, 1'b0);
    wr(8'h10, 32'h1);
    chk(rsp, `ADCCS_RESP_SLVERR);
    rdw(8'h10);
    chk(rd, 32'h0);
    chk(rsp, `ADCCS_RESP_SLVERR);
    // A write without lane 0 must leave the control byte untouched.
    s_axi_wstrb <= 4'h0;
    wr(`ADCCS_OFF_CTRL, 32'h7C);
    s_axi_wstrb <= 4'hF;
    rdw(`ADCCS_OFF_CTRL);
    chk(rd, 32'h01);
    $display("Test refusals finished");
  endtask

  // A low clock enable freezes the sequencer and the done filter.
  task automatic test_freeze();
    wr(`ADCCS_OFF_ICLR, 32'h1);
    wr(`ADCCS_OFF_CTRL, 32'h03);
    @(posedge clk);
    ce <= 1'b0;
    conv_done <= 1'b1;
    repeat (8) @(posedge clk);
    conv_done <= 1'b0;
    repeat (4) @(posedge clk);
    chk(converter_power_on, 1'b1);
    ce <= 1'b1;
    rdw(`ADCCS_OFF_CTRL);
    chk(rd, 32'h03);
    rdw(`ADCCS_OFF_STS);
    chk(rd, 32'h0);
    done_pulse();
    rdw(`ADCCS_OFF_CTRL);
    chk(rd, 32'h01);
    $display("Test freeze finished");
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Watchdog, far beyond the few hundred cycles the tests need.
  initial
  begin
    #500000;
    err_count++;
    stop_test();
  end

  // Main sequence: inputs quiet at time zero, reset for four cycles.
  initial
  begin
    rst_b = 1'b0;
    ce = 1'b1;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    conv_done = 1'b0;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    test_reset();
    test_routes();
    test_conv();
    test_refuse();
    test_freeze();
    stop_test();
  end
endmodule

// *** adccs_defs.svh ***
// Register offsets, field positions, codes and reset values for adccs.
`ifndef ADCCS_DEFS_SVH
`define ADCCS_DEFS_SVH

// ----------------------------------------------------------------------
// Register byte offsets on the AXI4-Lite slave
// ----------------------------------------------------------------------
`define ADCCS_OFF_CTRL 8'h00
`define ADCCS_OFF_STS 8'h04
`define ADCCS_OFF_IEN 8'h08
`define ADCCS_OFF_ICLR 8'h0C

// ----------------------------------------------------------------------
// Control register fields and reset value
// ----------------------------------------------------------------------
`define ADCCS_BIT_PWR 0
`define ADCCS_BIT_GO 1
`define ADCCS_SEL_LO 2
`define ADCCS_SEL_HI 6
`define ADCCS_BIT_UNIMP 7
`define ADCCS_RST_SEL 5'h00

// ----------------------------------------------------------------------
// Input route codes
// ----------------------------------------------------------------------
`define ADCCS_NUM_AIN 12
`define ADCCS_CODE_AIN_MAX 5'h0B
`define ADCCS_CODE_RSV_LO 5'h0C
`define ADCCS_CODE_RSV_HI 5'h1C
`define ADCCS_CODE_TEMP 5'h1D
`define ADCCS_CODE_LADDER 5'h1E
`define ADCCS_CODE_FIXREF 5'h1F

// ----------------------------------------------------------------------
// Bus answers and interrupt bit
// ----------------------------------------------------------------------
`define ADCCS_RESP_OKAY 2'h0
`define ADCCS_RESP_SLVERR 2'h2
`define ADCCS_IRQ_DONE 0

`endif

// *** adccs_pkg.sv ***
// Types shared by the adccs control block and its route decoder.
package adccs_pkg;
  `include "adccs_defs.svh"

  // One select line per possible converter input; at most one is high.
  typedef struct packed {
    logic fixref;
    logic ladder;
    logic temp;
    logic [`ADCCS_NUM_AIN-1:0] ain;
  } adccs_route_t;

  // Conversion sequencer states.
  typedef enum logic {
    ADCCS_IDLE,
    ADCCS_BUSY
  } adccs_conv_t;
endpackage

// *** adccs_route_dec.sv ***
// Registered decoder from the route code to one-hot analog switch selects.
`timescale 1ns/1ps
`include "adccs_defs.svh"

module adccs_route_dec (
  // Clock, reset and enable.
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  // Route code from the control register.
  input wire logic [4:0] sel,
  // Registered switch selects.
  output adccs_pkg::adccs_route_t route_r
);

  // ----------------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------------
  // Reserved codes match nothing below, so every select stays low.
  logic [`ADCCS_NUM_AIN-1:0] ain_hit;
  adccs_pkg::adccs_route_t route_nxt;

  // One comparator per external input.
  for (genvar i = 0; i < `ADCCS_NUM_AIN; i++)
  begin : g_ain
    assign ain_hit[i] = (sel == 5'(i));
  end

  assign route_nxt.ain = ain_hit;
  assign route_nxt.temp = (sel == `ADCCS_CODE_TEMP);
  assign route_nxt.ladder = (sel == `ADCCS_CODE_LADDER);
  assign route_nxt.fixref = (sel == `ADCCS_CODE_FIXREF);

  // Registering keeps the switch controls glitch free on a code change.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      route_r <= '0;
    else if (ce)
      route_r <= route_nxt;
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  property p_ain_route;
    @(posedge clk) disable iff (!rst_b)
    (ce && sel <= `ADCCS_CODE_AIN_MAX) |=>
      route_r.ain == (12'h001 << $past(sel)) &&
      !route_r.temp && !route_r.ladder && !route_r.fixref;
  endproperty
  a_ain_route: assert property (p_ain_route)
    else $error("external input select does not follow the code");

  property p_rsv_route;
    @(posedge clk) disable iff (!rst_b)
    (ce && sel >= `ADCCS_CODE_RSV_LO && sel <= `ADCCS_CODE_RSV_HI)
      |=> route_r == '0;
  endproperty
  a_rsv_route: assert property (p_rsv_route)
    else $error("a reserved code connected an input");

  property p_temp_route;
    @(posedge clk) disable iff (!rst_b)
    (ce && sel == `ADCCS_CODE_TEMP) |=>
      route_r.temp && route_r.ain == '0 && !route_r.ladder;
  endproperty
  a_temp_route: assert property (p_temp_route)
    else $error("temperature code did not select the indicator");

  property p_ref_route;
    @(posedge clk) disable iff (!rst_b)
    (ce && sel[4:1] == 4'hF) |=>
      route_r.ladder == ($past(sel) == `ADCCS_CODE_LADDER) &&
      route_r.fixref == ($past(sel) == `ADCCS_CODE_FIXREF);
  endproperty
  a_ref_route: assert property (p_ref_route)
    else $error("ladder or reference select is wrong");

endmodule
